// ### hw/dif_pkg.sv
// package for the dma interrupt flag logic: offsets, field layout, reset values
// assumes a 32-bit apb register bus and eight channels
`default_nettype none

package dif_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [15:0] DIF_OFF_FLAGS    = 16'h1000;
  localparam logic [15:0] DIF_OFF_FLAG_SET = 16'h1004;
  localparam logic [15:0] DIF_OFF_FLAG_CLR = 16'h1008;
  localparam logic [15:0] DIF_OFF_ENABLE   = 16'h100C;
  // ==========================================================
  // field layout
  localparam int          DIF_NUM_CHAN     = 8;
  localparam int          DIF_ERR_BIT      = 31;
  localparam logic [31:0] DIF_FLAG_MASK    = 32'h800000FF;
  // ==========================================================
  // reset values
  localparam logic [31:0] DIF_FLAGS_RESET  = 32'h00000000;
  localparam logic [31:0] DIF_ENABLE_RESET = 32'h00000000;
  // ==========================================================
  // bus states
  typedef enum logic {DIF_IDLE, DIF_ACCESS} dif_bus_state_type;
endpackage : dif_pkg

`default_nettype wire

// ### hw/dif_regif.sv
// interface carrying decoded register strobes from the apb slave to the flag core
// assumes a single clock domain; strobes are one-cycle pulses
`default_nettype none

interface dif_regif;
  logic        set_we;   // write pulse to flag-set
  logic        clr_we;   // write pulse to flag-clear
  logic [31:0] wdata;    // write data for the pulse
  logic [31:0] flags;    // current flag state
  modport core (input set_we, input clr_we, input wdata, output flags);
  modport bus  (output set_we, output clr_we, output wdata, input flags);
endinterface : dif_regif

`default_nettype wire

// ### hw/dif_flag_core.sv
// sticky flag store: hardware events and software set/clear
// assumes events are same-clock single-cycle or level signals from the controller
`default_nettype none

module dif_flag_core
  import dif_pkg::*;
#(
  parameter int NUM_CHAN = DIF_NUM_CHAN
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic [NUM_CHAN-1:0] chan_done,
  input  wire logic [NUM_CHAN-1:0] chan_req,
  input  wire logic [NUM_CHAN-1:0] chan_enabled,
  input  wire logic                bus_error,
  dif_regif.core                   rif
);
  logic [31:0] flags;
  logic [31:0] next_flags;
  logic [31:0] hw_set;
  logic [31:0] sw_set;
  logic [31:0] sw_clr;

  // ==========================================================
  // event gathering, one slice per channel
  genvar g;
  generate
    for (g = 0; g < NUM_CHAN; g++) begin : g_chan
      // a disabled channel flags on request instead of moving data
      assign hw_set[g] = chan_done[g] | (chan_req[g] & ~chan_enabled[g]);
    end
  endgenerate
  assign hw_set[30:NUM_CHAN]  = '0;
  assign hw_set[DIF_ERR_BIT]  = bus_error;
  // reserved positions are masked so stray software ones never stick
  assign sw_set = rif.set_we ? (rif.wdata & DIF_FLAG_MASK) : '0;
  assign sw_clr = rif.clr_we ? (rif.wdata & DIF_FLAG_MASK) : '0;

  // ==========================================================
  // next value: set wins over clear so no event is lost
  always_comb begin
    next_flags = ((flags & ~sw_clr) | sw_set | hw_set) & DIF_FLAG_MASK;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= DIF_FLAGS_RESET;
    end else begin
      flags <= next_flags;
    end
  end

  assign rif.flags = flags;

  a_hw_event_sets : assert property (@(posedge pclk) disable iff (!presetn)
    bus_error |=> flags[DIF_ERR_BIT])
    else $error("bus error did not set error flag");
  a_done_sets_flag : assert property (@(posedge pclk) disable iff (!presetn)
    chan_done[0] |=> flags[0])
    else $error("channel 0 completion not flagged");
  a_disabled_req_flag : assert property (@(posedge pclk) disable iff (!presetn)
    (chan_req[1] && !chan_enabled[1]) |=> flags[1])
    else $error("request on disabled channel 1 not flagged");
endmodule : dif_flag_core

`default_nettype wire

// ### hw/dif_top.sv
// Contract
// - bus error sets flag bit 31
// - channel completion sets its flag bit
// - disabled channel request sets its flag
// - flag-set bit 31 sets error flag
// - flag-set low bits set channel flags
// - flag-clear ones clear matching flags
// - enable register, same layout, resets zero
//
// top of the dma interrupt flag logic: apb slave, enable register, irq output
// assumes apb master on pclk and controller events on the same clock
//
// The APB slave port was left to the implementer.
`default_nettype none

module dif_top
  import dif_pkg::*;
#(
  parameter int NUM_CHAN = DIF_NUM_CHAN
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [15:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic [NUM_CHAN-1:0] chan_done,
  input  wire logic [NUM_CHAN-1:0] chan_req,
  input  wire logic [NUM_CHAN-1:0] chan_enabled,
  input  wire logic                bus_error,
  output logic                     irq
);
  dif_regif rif ();

  dif_bus_state_type state;
  dif_bus_state_type next_state;
  logic [31:0]       irq_enable_reg;
  logic [31:0]       next_irq_enable_reg;
  logic [31:0]       next_prdata;
  logic              next_pready;
  logic              next_pslverr;
  logic              next_irq;
  logic              next_set_we;
  logic              next_clr_we;
  logic [31:0]       next_wdata;
  logic              set_we;
  logic              clr_we;
  logic [31:0]       wdata;
  logic              hit;
  logic              wr_take;

  // ==========================================================
  // flag store
  dif_flag_core #(.NUM_CHAN(NUM_CHAN)) u_core (
    .pclk         (pclk),
    .presetn      (presetn),
    .chan_done    (chan_done),
    .chan_req     (chan_req),
    .chan_enabled (chan_enabled),
    .bus_error    (bus_error),
    .rif          (rif)
  );

  assign rif.set_we = set_we;
  assign rif.clr_we = clr_we;
  assign rif.wdata  = wdata;

  // ==========================================================
  // apb slave: one wait state, answer registered in the access phase
  assign hit = (paddr == DIF_OFF_FLAGS) || (paddr == DIF_OFF_FLAG_SET) ||
               (paddr == DIF_OFF_FLAG_CLR) || (paddr == DIF_OFF_ENABLE);
  assign wr_take = psel && penable && pready && pwrite && hit;

  always_comb begin
    next_state          = state;
    next_pready         = 1'b0;
    next_pslverr        = 1'b0;
    next_prdata         = prdata;
    next_irq_enable_reg = irq_enable_reg;
    next_set_we         = 1'b0;
    next_clr_we         = 1'b0;
    next_wdata          = wdata;
    unique case (state)
      DIF_IDLE: begin
        if (psel && penable) begin
          next_state   = DIF_ACCESS;
          next_pready  = 1'b1;
          next_pslverr = !hit;
          next_prdata  = 32'h00000000;
          if (!pwrite) begin
            // set and clear registers are write-only and read back zero
            if (paddr == DIF_OFF_FLAGS) begin
              next_prdata = rif.flags;
            end else if (paddr == DIF_OFF_ENABLE) begin
              next_prdata = irq_enable_reg;
            end
          end
        end
      end
      DIF_ACCESS: begin
        next_state = DIF_IDLE;
        // enable write takes effect on the edge that samples pready; set and clear reach the flags one edge later
        if (wr_take) begin
          // software should keep bits 30:8 zero; they are dropped here
          next_wdata = pwdata & DIF_FLAG_MASK;
          if (paddr == DIF_OFF_FLAG_SET) begin
            next_set_we = 1'b1;
          end
          if (paddr == DIF_OFF_FLAG_CLR) begin
            next_clr_we = 1'b1;
          end
          if (paddr == DIF_OFF_ENABLE) begin
            next_irq_enable_reg = pwdata & DIF_FLAG_MASK;
          end
        end
      end
    endcase
  end

  // ==========================================================
  // interrupt request: or of enabled flags, registered
  always_comb begin
    next_irq = |(rif.flags & irq_enable_reg);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state          <= DIF_IDLE;
      pready         <= 1'b0;
      pslverr        <= 1'b0;
      prdata         <= 32'h00000000;
      irq_enable_reg <= DIF_ENABLE_RESET;
      set_we         <= 1'b0;
      clr_we         <= 1'b0;
      wdata          <= 32'h00000000;
      irq            <= 1'b0;
    end else begin
      state          <= next_state;
      pready         <= next_pready;
      pslverr        <= next_pslverr;
      prdata         <= next_prdata;
      irq_enable_reg <= next_irq_enable_reg;
      set_we         <= next_set_we;
      clr_we         <= next_clr_we;
      wdata          <= next_wdata;
      irq            <= next_irq;
    end
  end

  // ==========================================================
  // checks
  sequence s_set_write;
    wr_take && paddr == DIF_OFF_FLAG_SET;
  endsequence

  sequence s_clr_write;
    wr_take && paddr == DIF_OFF_FLAG_CLR && !bus_error;
  endsequence

  a_set_err_flag : assert property (@(posedge pclk) disable iff (!presetn)
    s_set_write ##0 pwdata[DIF_ERR_BIT] |-> ##2 rif.flags[DIF_ERR_BIT])
    else $error("flag-set write did not set error flag");
  a_set_chan_flag : assert property (@(posedge pclk) disable iff (!presetn)
    s_set_write ##0 pwdata[0] |-> ##2 rif.flags[0])
    else $error("flag-set write did not set channel 0 flag");
  a_clr_err_flag : assert property (@(posedge pclk) disable iff (!presetn)
    s_clr_write ##0 pwdata[DIF_ERR_BIT] ##1 !bus_error |=> !rif.flags[DIF_ERR_BIT])
    else $error("flag-clear write did not clear error flag");
  a_enable_store : assert property (@(posedge pclk) disable iff (!presetn)
    wr_take && paddr == DIF_OFF_ENABLE |=>
      irq_enable_reg == ($past(pwdata) & DIF_FLAG_MASK))
    else $error("enable register not updated");
  a_irq_follows : assert property (@(posedge pclk) disable iff (!presetn)
    |(rif.flags & irq_enable_reg) |=> irq)
    else $error("irq low with enabled flag set");
  a_irq_quiet : assert property (@(posedge pclk) disable iff (!presetn)
    !$past(next_irq) |-> !irq)
    else $error("irq high with no enabled flag");
  a_ready_one_cycle : assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("pready held beyond one cycle");
  a_reserved_zero : assert property (@(posedge pclk) disable iff (!presetn)
    (rif.flags[30:8] == 23'h000000) && (irq_enable_reg[30:8] == 23'h000000))
    else $error("reserved bits became set");
endmodule : dif_top

`default_nettype wire

// ### testbench/dif_ctrl_model.sv
// stand-in for the dma controller: turns bench commands into channel events
// assumes the bench raises go for exactly one pclk cycle per command
`default_nettype none

module dif_ctrl_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       go,
  input  wire logic [7:0] done_in,
  input  wire logic [7:0] req_in,
  input  wire logic [7:0] en_in,
  input  wire logic       err_in,
  output logic      [7:0] chan_done,
  output logic      [7:0] chan_req,
  output logic      [7:0] chan_enabled,
  output logic            bus_error
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // events last one cycle; enable is a level kept between commands
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_done    <= 8'h00;
      chan_req     <= 8'h00;
      chan_enabled <= 8'h00;
      bus_error    <= 1'b0;
    end else begin
      chan_done    <= go ? done_in : 8'h00;
      chan_req     <= go ? req_in : 8'h00;
      chan_enabled <= en_in;
      bus_error    <= go & err_in;
    end
  end
endmodule : dif_ctrl_model

`default_nettype wire

// ### testbench/testbench.sv
// self-checking bench for the dma interrupt flag logic over apb
// assumes dif_top with eight channels and a one-wait-state apb slave
`default_nettype none

module testbench
  import dif_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic        bus_error, go, err_in;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, s, f, en, r;
  logic [7:0]  chan_done, chan_req, chan_enabled, done_in, req_in, en_in;
  int          fails, tests_run;
  logic        e;

  dif_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .chan_done(chan_done), .chan_req(chan_req),
    .chan_enabled(chan_enabled), .bus_error(bus_error), .irq(irq));
  dif_ctrl_model u_ctrl (.pclk(pclk), .presetn(presetn), .go(go), .done_in(done_in),
    .req_in(req_in), .en_in(en_in), .err_in(err_in), .chan_done(chan_done),
    .chan_req(chan_req), .chan_enabled(chan_enabled), .bus_error(bus_error));

  // ==========================================================
  // expectation and stimulus helpers
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  // disabled-channel requests flag at once; enabled ones wait for completion
  function automatic logic [31:0] exp_ev(input logic [31:0] o, input logic [7:0] d,
                                         input logic [7:0] q, input logic [7:0] n,
                                         input logic x);
    exp_ev = o | {x, 23'h0, d | (q & ~n)};
  endfunction : exp_ev
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    tests_run++;
    if (g !== x) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x, g);
    end
  endtask : chk
  // request held until pready seen high; an idle edge follows every transfer
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle limit here: the watchdog ends a hung wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rd(input string nm, input logic [15:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(nm, x, r);
  endtask : rd
  task automatic ev(input logic [7:0] d, input logic [7:0] q, input logic [7:0] n,
                    input logic x);
    go <= 1'b1; done_in <= d; req_in <= q; en_in <= n; err_in <= x;
    @(posedge pclk);
    go <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask : ev
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report

  // ==========================================================
  // clock, watchdog, main sequence
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    final_report();
  end
  initial begin
    fails = 0; tests_run = 0; presetn = 1'b0; psel = 1'b0; penable = 1'b0;
    pwrite = 1'b0; paddr = 16'h0; pwdata = 32'h0; go = 1'b0; done_in = 8'h0;
    req_in = 8'h0; en_in = 8'h0; err_in = 1'b0; s = 32'h1382; f = 32'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd("flags_reset", DIF_OFF_FLAGS, 32'h0);
    rd("enable_reset", DIF_OFF_ENABLE, 32'h0);
    apb(1'b0, 16'h1010, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, e});
    apb(1'b1, DIF_OFF_FLAG_SET, DIF_FLAG_MASK);
    rd("flags_all_set", DIF_OFF_FLAGS, DIF_FLAG_MASK);
    rd("set_reads_zero", DIF_OFF_FLAG_SET, 32'h0);
    apb(1'b1, DIF_OFF_ENABLE, DIF_FLAG_MASK);
    // irq is registered one edge after the enable lands
    @(posedge pclk);
    chk("irq_on", 32'h1, {31'h0, irq});
    apb(1'b1, DIF_OFF_FLAG_CLR, DIF_FLAG_MASK);
    rd("flags_all_clr", DIF_OFF_FLAGS, 32'h0);
    chk("irq_off", 32'h0, {31'h0, irq});
    // random mix of software set, events, enables and clears
    for (int i = 0; i < 40; i++) begin
      s = lfsr(s);
      apb(1'b1, DIF_OFF_FLAG_SET, s & DIF_FLAG_MASK);
      f = f | (s & DIF_FLAG_MASK);
      s = lfsr(s);
      en = s & DIF_FLAG_MASK;
      apb(1'b1, DIF_OFF_ENABLE, en);
      rd("enable", DIF_OFF_ENABLE, en);
      s = lfsr(s);
      ev(s[7:0], s[15:8], s[23:16], s[31]);
      f = exp_ev(f, s[7:0], s[15:8], s[23:16], s[31]);
      rd("flags_ev", DIF_OFF_FLAGS, f);
      s = lfsr(s);
      apb(1'b1, DIF_OFF_FLAG_CLR, s & DIF_FLAG_MASK);
      f = f & ~(s & DIF_FLAG_MASK);
      rd("flags_clr", DIF_OFF_FLAGS, f);
      chk("irq", {31'h0, |(f & en)}, {31'h0, irq});
    end
    final_report();
  end
endmodule : testbench

`default_nettype wire
